/* rtl/sync_serial_defs.svh */
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH
`define TXSC_OFFSET 8'h00
`define RCSC_OFFSET 8'h04
`define BAUD_OFFSET 8'h08
`define TXD_OFFSET 8'h0c
`define RXD_OFFSET 8'h10
`define IRQ_OFFSET 8'h14
`define TXSC_CLOCK_SOURCE_MASTER_BIT 7
`define TXSC_TX9_BIT 6
`define TXSC_TRANSMIT_ENABLE_BIT 5
`define TXSC_SYNC_BIT 4
`define TXSC_TRMT_BIT 1
`define TXSC_TRANSMIT_NINTH_BIT_BIT 0
`define RCSC_PORT_ENABLE_BIT 7
`define RCSC_RX9_BIT 6
`define RCSC_SINGLE_RECEIVE_ENABLE_BIT 5
`define RCSC_CONTINUOUS_RECEIVE_ENABLE_BIT 4
`define RCSC_OVERRUN_FLAG_BIT 1
`define RCSC_RECEIVE_NINTH_BIT_BIT 0
`define BAUD_CLOCK_POLARITY_BIT 4
`define BAUD_RCIDL_BIT 6
`define IRQ_TRANSMIT_IRQ_ENABLE_BIT 0
`define IRQ_RECEIVE_IRQ_ENABLE_BIT 1
`define IRQ_PERIPHERAL_IRQ_ENABLE_BIT 2
`define IRQ_GIE_BIT 3
`define IRQ_TXF_BIT 4
`define IRQ_RXF_BIT 5
`define TXSC_RESET 8'h02
`define RCSC_RESET 8'h00
`define BAUD_RESET 8'h00
`define IRQ_RESET 8'h00
`define ISR_VECTOR 16'h0004
`define MASTER_CLK_DIV 8'd8
`endif

/* rtl/sync_serial_pkg.sv */
`default_nettype none
package sync_serial_pkg;
   typedef enum logic [3:0] {
      M_IDLE = 4'b0001,
      M_ADDR = 4'b0010,
      M_DATA = 4'b0100,
      M_DONE = 4'b1000
   } bus_state_e;
   typedef logic [8:0] word_t;
endpackage : sync_serial_pkg
`default_nettype wire

/* rtl/sync_serial_if.sv */
`default_nettype none
interface sync_serial_if;
   logic ck_o;
   logic ck_oe_n;
   logic dt_dev_o;
   logic dt_dev_oe_n;
   logic dt_mst_o;
   logic dt_mst_oe_n;
   logic ck_i;
   logic dt_i;
   modport device (
      input ck_i, dt_i,
      output ck_o, ck_oe_n, dt_dev_o, dt_dev_oe_n
   );
   modport master (
      input ck_i, dt_i,
      output dt_mst_o, dt_mst_oe_n
   );
endinterface : sync_serial_if
`default_nettype wire

/* rtl/sync_serial_master_end.sv */
`include "sync_serial_defs.svh"
`default_nettype none
module sync_serial_master_end
   import sync_serial_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   sync_serial_if.master link,
   input wire logic start,
   input wire logic receive,
   input wire logic [3:0] bit_count,
   input wire logic [8:0] send_word,
   output logic busy,
   output logic done,
   output logic [8:0] recv_word,
   output logic ck_drive
);
   // clock: rises (leading) then falls (trailing), idles low
   logic [7:0] div_r;
   logic [4:0] edges_r;
   logic rx_r;
   logic [8:0] sh_r;
   logic [1:0] dt_sync_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dt_sync_r <= 2'b00;
      end else if (ce) begin
         dt_sync_r <= {dt_sync_r[0], link.dt_i};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r <= 8'h00;
         edges_r <= 5'h00;
         ck_drive <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         rx_r <= 1'b0;
         sh_r <= 9'h000;
         recv_word <= 9'h000;
         link.dt_mst_o <= 1'b0;
         link.dt_mst_oe_n <= 1'b1;
      end else if (ce) begin
         done <= 1'b0;
         if (!busy) begin
            if (start) begin
               busy <= 1'b1;
               rx_r <= receive;
               edges_r <= {bit_count, 1'b0};
               sh_r <= send_word;
               div_r <= 8'h00;
               link.dt_mst_oe_n <= receive;
               link.dt_mst_o <= send_word[0];
            end
         end else if (div_r == `MASTER_CLK_DIV - 8'd1) begin
            div_r <= 8'h00;
            if (edges_r == 5'h00) begin
               busy <= 1'b0;
               done <= 1'b1;
               ck_drive <= 1'b0;
               link.dt_mst_oe_n <= 1'b1;
               recv_word <= rx_r ? (sh_r >> (5'd9 - {1'b0, bit_count})) : 9'h000;
            end else begin
               edges_r <= edges_r - 5'h01;
               ck_drive <= !ck_drive;
               if (ck_drive && rx_r) begin
                  sh_r <= {dt_sync_r[1], sh_r[8:1]};
               end else if (!ck_drive && !rx_r && edges_r != {bit_count, 1'b0}) begin
                  sh_r <= {1'b0, sh_r[8:1]};
                  link.dt_mst_o <= sh_r[1];
               end
            end
         end else begin
            div_r <= div_r + 8'h01;
         end
      end
   end
endmodule : sync_serial_master_end
`default_nettype wire

/* rtl/sync_serial_slave_port.sv */
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`include "sync_serial_defs.svh"
`default_nettype none
// How it works
// - slave when sync, not master-clock, enabled
// - transmit when both receive enables clear
// - first write loads shifter, second waits
// - shifter drained: load held, set transmit flag
// - transmit flag plus enables wakes device
// - slave receiver never idle while enabled
// - single receive enable ignored by slave receive, still blocks transmit
// - full word moves to buffer, wakes
// - clearing receive or port enable clears overrun
// - only slave mode shifts during sleep
// - shifters clocked by external bit clock
// - master supplies clock and receive data
// - device drives data, master drives clock
// - holding write clears transmit flag
// - data read pops buffer, flag clears when empty
// - wake with global enable vectors 004h
// - ninth bit loaded before low byte
// - transmit starts after enable by write
// - ninth bit read before low byte
// - receive enable set before sleep
// - data changes leading edge, one bit each
// - clock pin driver off in slave
// - two-deep buffer, third sets overrun
// - polarity clear: idle low, rising change
module sync_serial_slave_port
   import sync_serial_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   sync_serial_if.device link,
   input wire logic sleep,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic wake,
   output logic irq_vector_take,
   output logic [15:0] irq_vector
);
   logic [7:0] txsc_r;
   logic [7:0] rcsc_r;
   logic [7:0] baud_r;
   logic [3:0] ien_r;
   logic [7:0] thr_r;
   logic thr9_r;
   logic thr_full_r;
   word_t tsr_r;
   logic [3:0] tcnt_r;
   logic tsr_busy_r;
   logic txf_r;
   word_t rsr_r;
   logic [3:0] rcnt_r;
   word_t fifo_r [0:1];
   logic [1:0] fcnt_r;
   logic rd_ptr_r;
   logic overrun_flag_r;
   logic [1:0] ck_sync_r;
   logic ck_d_r;
   logic [1:0] dt_sync_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic slave, tx_mode, rx_mode, lead, trail, ck_lvl;
   logic bus_wr, bus_rd, rd_rxd, wr_txd, wr_rcsc;
   logic [3:0] nbits;
   assign slave = txsc_r[`TXSC_SYNC_BIT] && !txsc_r[`TXSC_CLOCK_SOURCE_MASTER_BIT] && rcsc_r[`RCSC_PORT_ENABLE_BIT];
   assign tx_mode = slave && !rcsc_r[`RCSC_SINGLE_RECEIVE_ENABLE_BIT] && !rcsc_r[`RCSC_CONTINUOUS_RECEIVE_ENABLE_BIT];
   assign rx_mode = slave && rcsc_r[`RCSC_CONTINUOUS_RECEIVE_ENABLE_BIT];
   // sleep freezes nothing here: external clock keeps shifting
   assign ck_lvl = ck_sync_r[1] ^ baud_r[`BAUD_CLOCK_POLARITY_BIT];
   assign lead = ck_lvl && !ck_d_r;
   assign trail = !ck_lvl && ck_d_r;
   assign bus_wr = hsel && hready && htrans[1] && hwrite;
   assign bus_rd = hsel && hready && htrans[1] && !hwrite;
   assign rd_rxd = bus_rd && haddr[7:0] == `RXD_OFFSET;
   assign wr_txd = wr_pend_r && wr_addr_r == `TXD_OFFSET;
   assign wr_rcsc = wr_pend_r && wr_addr_r == `RCSC_OFFSET;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign nbits = 4'd8 + {3'd0, txsc_r[`TXSC_TX9_BIT]};
   assign link.ck_o = 1'b0;
   assign link.ck_oe_n = 1'b1;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_sync_r <= 2'b00;
         dt_sync_r <= 2'b00;
         ck_d_r <= 1'b0;
      end else if (ce) begin
         ck_sync_r <= {ck_sync_r[0], link.ck_i};
         dt_sync_r <= {dt_sync_r[0], link.dt_i};
         ck_d_r <= ck_lvl;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (ce) begin
         wr_pend_r <= bus_wr;
         wr_addr_r <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txsc_r <= `TXSC_RESET;
         rcsc_r <= `RCSC_RESET;
         baud_r <= `BAUD_RESET;
         ien_r <= 4'h0;
      end else if (ce && wr_pend_r) begin
         case (wr_addr_r)
            `TXSC_OFFSET: txsc_r <= hwdata[7:0];
            `RCSC_OFFSET: rcsc_r <= hwdata[7:0];
            `BAUD_OFFSET: baud_r <= hwdata[7:0];
            `IRQ_OFFSET: ien_r <= hwdata[3:0];
            default: ;
         endcase
      end
   end
   // transmit path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thr_r <= 8'h00;
         thr9_r <= 1'b0;
         thr_full_r <= 1'b0;
         tsr_r <= 9'h000;
         tcnt_r <= 4'h0;
         tsr_busy_r <= 1'b0;
         txf_r <= 1'b1;
         link.dt_dev_o <= 1'b0;
         link.dt_dev_oe_n <= 1'b1;
      end else if (ce) begin
         link.dt_dev_oe_n <= !(tx_mode && txsc_r[`TXSC_TRANSMIT_ENABLE_BIT]);
         if (!rcsc_r[`RCSC_PORT_ENABLE_BIT]) begin
            thr_full_r <= 1'b0;
            tsr_busy_r <= 1'b0;
            txf_r <= 1'b1;
         end else begin
            if (tsr_busy_r && tcnt_r == 4'h0 && trail) begin
               tsr_busy_r <= 1'b0;
            end else if (tsr_busy_r && lead) begin
               link.dt_dev_o <= tsr_r[0];
               tsr_r <= {1'b0, tsr_r[8:1]};
               tcnt_r <= tcnt_r - 4'h1;
            end
            if (wr_txd && txsc_r[`TXSC_TRANSMIT_ENABLE_BIT]) begin
               thr_r <= hwdata[7:0];
               thr9_r <= txsc_r[`TXSC_TRANSMIT_NINTH_BIT_BIT];
               thr_full_r <= 1'b1;
               txf_r <= 1'b0;
            end else if (thr_full_r && !tsr_busy_r && tx_mode) begin
               tsr_r <= {thr9_r, thr_r};
               tcnt_r <= nbits;
               tsr_busy_r <= 1'b1;
               thr_full_r <= 1'b0;
               txf_r <= 1'b1;
            end
         end
      end
   end
   // receive path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rsr_r <= 9'h000;
         rcnt_r <= 4'h0;
         fifo_r[0] <= 9'h000;
         fifo_r[1] <= 9'h000;
         fcnt_r <= 2'd0;
         rd_ptr_r <= 1'b0;
         overrun_flag_r <= 1'b0;
      end else if (ce) begin
         if (!rcsc_r[`RCSC_PORT_ENABLE_BIT]) begin
            fcnt_r <= 2'd0;
            rcnt_r <= 4'h0;
            overrun_flag_r <= 1'b0;
         end else begin
            if (!rx_mode) begin
               rcnt_r <= 4'h0;
            end else if (trail && !overrun_flag_r) begin
               rsr_r <= {dt_sync_r[1], rsr_r[8:1]};
               rcnt_r <= rcnt_r + 4'h1;
            end else if (rcnt_r == (rcsc_r[`RCSC_RX9_BIT] ? 4'd9 : 4'd8)) begin
               rcnt_r <= 4'h0;
               if (fcnt_r == 2'd2 && !(rd_rxd)) begin
                  overrun_flag_r <= 1'b1;
               end else begin
                  fifo_r[rd_ptr_r ^ fcnt_r[0] ^ (rd_rxd ? 1'b1 : 1'b0)] <= rcsc_r[`RCSC_RX9_BIT] ?
                     rsr_r : {1'b0, rsr_r[8:1]};
               end
            end
            if (rd_rxd && fcnt_r != 2'd0) begin
               rd_ptr_r <= !rd_ptr_r;
            end
            fcnt_r <= fcnt_r + {1'b0, (rcnt_r == (rcsc_r[`RCSC_RX9_BIT] ? 4'd9 : 4'd8)) && rx_mode
               && !(trail && !overrun_flag_r) && !(fcnt_r == 2'd2 && !rd_rxd)}
               - {1'b0, rd_rxd && fcnt_r != 2'd0};
            if (wr_rcsc && !hwdata[`RCSC_CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
               overrun_flag_r <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ce && bus_rd) begin
         case (haddr[7:0])
            `TXSC_OFFSET: hrdata <= {24'h0, txsc_r[7:2], !tsr_busy_r, txsc_r[0]};
            `RCSC_OFFSET: hrdata <= {24'h0, rcsc_r[7:2], overrun_flag_r, fifo_r[rd_ptr_r][8]};
            `BAUD_OFFSET: hrdata <= {24'h0, baud_r[7], !rx_mode, baud_r[5:0]};
            `RXD_OFFSET: hrdata <= {24'h0, fifo_r[rd_ptr_r][7:0]};
            `IRQ_OFFSET: hrdata <= {26'h0, fcnt_r != 2'd0, txf_r, ien_r};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
   logic ev;
   assign ev = ien_r[`IRQ_PERIPHERAL_IRQ_ENABLE_BIT] && ((ien_r[`IRQ_TRANSMIT_IRQ_ENABLE_BIT] && txf_r) ||
      (ien_r[`IRQ_RECEIVE_IRQ_ENABLE_BIT] && fcnt_r != 2'd0));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake <= 1'b0;
         irq_vector_take <= 1'b0;
      end else if (ce) begin
         wake <= sleep && ev;
         irq_vector_take <= ev && ien_r[`IRQ_GIE_BIT];
      end
   end
   assign irq_vector = `ISR_VECTOR;
endmodule : sync_serial_slave_port
`default_nettype wire

/* tb/sync_serial_monitor.sv */
`default_nettype none
module sync_serial_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ck_o,
   input wire logic ck_oe_n,
   input wire logic dt_dev_o,
   input wire logic dt_dev_oe_n,
   input wire logic dt_mst_o,
   input wire logic dt_mst_oe_n,
   input wire logic ck_i,
   input wire logic dt_i
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ck_drv_off: assert property (ck_oe_n) else $error("clock driver on");
   a_ck_out_low: assert property (!ck_o) else $error("clock output high");
   a_one_driver: assert property (dt_dev_oe_n || dt_mst_oe_n) else $error("data contention");
   a_dt_moves_high: assert property (!dt_dev_oe_n && $past(!dt_dev_oe_n) && $changed(dt_dev_o)
      |-> ck_i) else $error("data moved off leading edge");
   a_high_half: assert property ($rose(ck_i) |-> ck_i [*8] ##1 !ck_i)
      else $error("clock high phase wrong");
   a_low_half: assert property ($fell(ck_i) |-> !ck_i [*8]) else $error("clock low phase short");
   a_mst_oe_idle: assert property ($changed(dt_mst_oe_n) |-> !ck_i)
      else $error("master data enable moved in clock");
   a_dev_oe_idle: assert property ($changed(dt_dev_oe_n) |-> !ck_i)
      else $error("device data enable moved in clock");
   c_frame: cover property ($rose(ck_i));
   c_dev_bit: cover property (!dt_dev_oe_n && $fell(ck_i));
   c_mst_bit: cover property (!dt_mst_oe_n && $fell(ck_i));
endmodule : sync_serial_monitor
`default_nettype wire

/* tb/sync_serial_slave_port_tb.sv */
`default_nettype none
module sync_serial_slave_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 0, hresetn = 0, sleep = 0, hsel = 0, hwrite = 0, start = 0, receive = 0, rd_dp = 0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, m1, m2;
   logic [3:0] bit_count = 4'h8;
   logic [8:0] send_word = 9'h0, recv_word;
   logic [8:0] v [6];
   logic [15:0] irq_vector;
   logic hreadyout, hresp, wake, irq_vector_take, busy, done, ck_drive;
   logic [31:0] rq[$], rmq[$], wq[$], wmq[$];
   int bad_count = 0, checks = 0;
   sync_serial_if link();
   assign link.ck_i = ck_drive;
   assign link.dt_i = !link.dt_dev_oe_n ? link.dt_dev_o : !link.dt_mst_oe_n ? link.dt_mst_o : 1'b1;
   sync_serial_slave_port sync_serial_slave_port_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .link(link.device), .sleep(sleep), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .wake(wake), .irq_vector_take(irq_vector_take), .irq_vector(irq_vector));
   sync_serial_master_end sync_serial_master_end_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .link(link.master), .start(start), .receive(receive), .bit_count(bit_count),
      .send_word(send_word), .busy(busy), .done(done), .recv_word(recv_word), .ck_drive(ck_drive));
   sync_serial_monitor sync_serial_monitor_inst (.hclk(hclk), .hresetn(hresetn), .ck_o(link.ck_o),
      .ck_oe_n(link.ck_oe_n), .dt_dev_o(link.dt_dev_o), .dt_dev_oe_n(link.dt_dev_oe_n),
      .dt_mst_o(link.dt_mst_o), .dt_mst_oe_n(link.dt_mst_oe_n), .ck_i(link.ck_i), .dt_i(link.dt_i));
   initial begin
      forever #10 hclk = ~hclk;
   end
   task automatic end_sim;
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask : chk
   // one bus transfer; a read notes expected value and mask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      if (!w) begin
         rq.push_back({24'h0, d & m});
         rmq.push_back({24'h0, m});
      end
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : bus
   // one link frame; rx means the master samples device data
   task automatic ms(input logic rx, input logic [3:0] n, input logic [8:0] w, input logic [8:0] e);
      @(posedge hclk);
      start <= 1'b1;
      receive <= rx;
      bit_count <= n;
      send_word <= w;
      if (rx) begin
         wq.push_back({23'h0, e});
         wmq.push_back(n == 4'h9 ? 32'h1ff : 32'hff);
      end
      @(posedge hclk);
      start <= 1'b0;
      repeat (2) @(posedge hclk);
      while (busy === 1'b1) @(posedge hclk);
      repeat (8) @(posedge hclk);
   endtask : ms
   always @(posedge hclk) begin
      rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
      if (rd_dp) begin
         m1 = rmq.pop_front();
         chk(rq.pop_front(), hrdata & m1);
      end
      if (done === 1'b1 && receive === 1'b1) begin
         m2 = wmq.pop_front();
         chk(wq.pop_front(), {23'h0, recv_word} & m2);
      end
   end
   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      end_sim;
   end
   initial begin
      void'($urandom(28));
      for (int i = 0; i < 6; i++)
         v[i] = 9'($urandom);
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, 8'h00, 8'h02, 8'hff);
      bus(0, 8'h04, 8'h00, 8'hff);
      bus(0, 8'h14, 8'h10, 8'hff);
      bus(0, 8'h18, 8'h00, 8'hff);
      bus(1, 8'h04, 8'h80, 8'h00);
      bus(1, 8'h00, 8'h30, 8'h00);
      bus(1, 8'h14, 8'h05, 8'h00);
      sleep <= 1'b1;
      bus(1, 8'h0c, v[0][7:0], 8'h00);
      bus(1, 8'h0c, v[1][7:0], 8'h00);
      bus(0, 8'h14, 8'h00, 8'h10);
      chk(32'h0, {31'h0, wake});
      ms(1, 4'h8, 9'h0, {1'b0, v[0][7:0]});
      chk(32'h1, {31'h0, wake});
      bus(0, 8'h14, 8'h10, 8'h10);
      bus(1, 8'h14, 8'h0d, 8'h00);
      repeat (2) @(posedge hclk);
      chk(32'h1, {31'h0, irq_vector_take});
      chk(32'h4, {16'h0, irq_vector});
      bus(1, 8'h0c, v[2][7:0], 8'h00);
      bus(0, 8'h14, 8'h00, 8'h10);
      ms(1, 4'h8, 9'h0, {1'b0, v[1][7:0]});
      ms(1, 4'h8, 9'h0, {1'b0, v[2][7:0]});
      bus(1, 8'h00, 8'h71, 8'h00);
      bus(1, 8'h0c, v[3][7:0], 8'h00);
      ms(1, 4'h9, 9'h0, {1'b1, v[3][7:0]});
      bus(1, 8'h00, 8'h10, 8'h00);
      bus(1, 8'h04, 8'hb0, 8'h00);
      bus(1, 8'h14, 8'h06, 8'h00);
      ms(0, 4'h8, v[0], 9'h0);
      chk(32'h1, {31'h0, wake});
      bus(0, 8'h14, 8'h20, 8'h20);
      bus(0, 8'h10, v[0][7:0], 8'hff);
      bus(0, 8'h14, 8'h00, 8'h20);
      for (int i = 1; i < 4; i++)
         ms(0, 4'h8, v[i], 9'h0);
      bus(0, 8'h04, 8'h02, 8'h02);
      bus(0, 8'h10, v[1][7:0], 8'hff);
      bus(0, 8'h10, v[2][7:0], 8'hff);
      bus(1, 8'h04, 8'h80, 8'h00);
      bus(0, 8'h04, 8'h00, 8'h02);
      bus(1, 8'h04, 8'hd0, 8'h00);
      ms(0, 4'h9, v[4], 9'h0);
      bus(0, 8'h04, {7'h0, v[4][8]}, 8'h01);
      bus(0, 8'h10, v[4][7:0], 8'hff);
      bus(1, 8'h00, 8'h90, 8'h00);
      bus(1, 8'h04, 8'h90, 8'h00);
      ms(0, 4'h8, v[5], 9'h0);
      bus(0, 8'h14, 8'h00, 8'h20);
      end_sim;
   end
endmodule : sync_serial_slave_port_tb
`default_nettype wire
